/* inc/ccbt_regs.svh */
// register offsets, field positions and reset values of the base timer
// assumes an axi4-lite slave with 32-bit data, one word per register
`ifndef CCBT_REGS_SVH
`define CCBT_REGS_SVH
`define CCBT_CTRL0_OFS 8'h00
`define CCBT_CTRL1_OFS 8'h04
`define CCBT_COUNT_OFS 8'h08
`define CCBT_RMATCH_OFS 8'h0C
`define CCBT_DIV_OFS 8'h10
`define CCBT_CH0CMP_OFS 8'h14
`define CCBT_STATUS_OFS 8'h18
// control zero fields
`define CCBT_SRC_LSB 0
`define CCBT_RMEN_BIT 2
`define CCBT_OVSEL_BIT 3
// control one fields
`define CCBT_CH0EN_BIT 0
`define CCBT_PINEN_BIT 1
`define CCBT_RUN_BIT 2
`define CCBT_METH_LSB 3
// status fields
`define CCBT_PEND_BIT 0
`define CCBT_RUNNING_BIT 1
`define CCBT_CTRL_RST 8'h00
`define CCBT_WORD_RST 16'h0000
`define CCBT_DIV_RST 8'h00
`endif

/* inc/ccbt_pkg.sv */
// types of the base timer
// assumes ccbt_regs.svh holds the numeric constants
package ccbt_pkg;
  typedef enum logic [1:0] {
    CCBT_SRC_CLK1 = 2'h0,
    CCBT_SRC_CLK2 = 2'h1,
    CCBT_SRC_QUAD = 2'h2,
    CCBT_SRC_RSVD = 2'h3
  } ccbt_src_t;
  typedef enum logic [1:0] {
    CCBT_METH_UP = 2'h0,
    CCBT_METH_UPDN = 2'h1,
    CCBT_METH_QUAD = 2'h2,
    CCBT_METH_RSVD = 2'h3
  } ccbt_meth_t;
  // write channel handshake, gray ordered
  typedef enum logic [1:0] {
    CCBT_W_IDLE = 2'h0,
    CCBT_W_RESP = 2'h1
  } ccbt_wst_t;
endpackage

/* design/ccbt_top.sv */
// base timer of the capture/compare unit with an axi4-lite register slave
// assumes clk enables for internal clocks one and two come from the same clock domain;
// quadrature inputs and the external pin are asynchronous
`timescale 1ns/1ps
`include "ccbt_regs.svh"
module ccbt_top #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // internal count clock enables
  input wire logic internal_clock_one,
  input wire logic internal_clock_two,
  // pins
  input wire logic quadrature_input_a,
  input wire logic quadrature_input_b,
  input wire logic external_interrupt_pin_one,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer state
  output logic base_timer_irq,
  output logic [CW-1:0] base_counter_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [CW-1:0] reset_match_value;
  logic [CW-1:0] channel0_compare_value;
  logic [7:0] count_source_divider;
  logic [CW-1:0] base_counter_value;
  logic pend;
  logic down_dir;
  logic match_hold;
  logic [2:0] qa_sync;
  logic [2:0] qb_sync;
  logic [2:0] pin_sync;
  logic qa_st;
  logic qb_st;
  logic pin_st;
  logic [7:0] div_cnt;
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  ccbt_pkg::ccbt_wst_t wst;

  // field views
  ccbt_pkg::ccbt_src_t count_source_select;
  ccbt_pkg::ccbt_meth_t count_method_select;
  logic reset_match_enable;
  logic overflow_bit_select;
  logic channel0_match_reset_enable;
  logic pin_reset_enable;
  logic timer_run_bit;
  assign count_source_select = ccbt_pkg::ccbt_src_t'(timer_control_zero[`CCBT_SRC_LSB +: 2]);
  assign reset_match_enable = timer_control_zero[`CCBT_RMEN_BIT];
  assign overflow_bit_select = timer_control_zero[`CCBT_OVSEL_BIT];
  assign channel0_match_reset_enable = timer_control_one[`CCBT_CH0EN_BIT];
  assign pin_reset_enable = timer_control_one[`CCBT_PINEN_BIT];
  assign timer_run_bit = timer_control_one[`CCBT_RUN_BIT];
  assign count_method_select = ccbt_pkg::ccbt_meth_t'(timer_control_one[`CCBT_METH_LSB +: 2]);

  // byte-lane merge for register writes
  function automatic logic [31:0] ccbt_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      qa_sync <= 3'h0;
      qb_sync <= 3'h0;
      pin_sync <= 3'h7;
      qa_st <= 1'b0;
      qb_st <= 1'b0;
      pin_st <= 1'b1;
    end else if (clk_en) begin
      qa_sync <= {qa_sync[1:0], quadrature_input_a};
      qb_sync <= {qb_sync[1:0], quadrature_input_b};
      pin_sync <= {pin_sync[1:0], external_interrupt_pin_one};
      if (qa_sync[1] == qa_sync[2]) qa_st <= qa_sync[2];
      if (qb_sync[1] == qb_sync[2]) qb_st <= qb_sync[2];
      if (pin_sync[1] == pin_sync[2]) pin_st <= pin_sync[2];
    end
  end

  // quadrature decode from the settled levels
  logic qa_d;
  logic qb_d;
  logic q_edge;
  logic q_up;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      qa_d <= 1'b0;
      qb_d <= 1'b0;
    end else if (clk_en) begin
      qa_d <= qa_st;
      qb_d <= qb_st;
    end
  end
  assign q_edge = (qa_st ^ qa_d) | (qb_st ^ qb_d); // all edges of both phases
  // a leading b: a ^ old b is high for that phase order
  assign q_up = qa_st ^ qb_d;

  ////////////////////////////////////////////////////////////////////////////
  // count source selection and divider
  logic src_pulse;
  logic tick;
  always_comb begin
    case (count_source_select)
      ccbt_pkg::CCBT_SRC_CLK1: src_pulse = internal_clock_one;
      ccbt_pkg::CCBT_SRC_CLK2: src_pulse = internal_clock_two;
      ccbt_pkg::CCBT_SRC_QUAD: src_pulse = q_edge;
      default: src_pulse = 1'b0;
    endcase
  end
  // divide by n+1; n of zero passes every pulse
  assign tick = src_pulse && (div_cnt == count_source_divider);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!timer_run_bit) begin
        div_cnt <= 8'h00;
      end else if (src_pulse) begin
        div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel
  logic wr_fire;
  assign wr_fire = aw_have && w_have && (wst == ccbt_pkg::CCBT_W_IDLE);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      wst <= ccbt_pkg::CCBT_W_IDLE;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      case (wst)
        ccbt_pkg::CCBT_W_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr > `CCBT_STATUS_OFS || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
            wst <= ccbt_pkg::CCBT_W_RESP;
          end
        end
        default: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            wst <= ccbt_pkg::CCBT_W_IDLE;
          end
        end
      endcase
    end
  end

  // control and value registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_control_zero <= `CCBT_CTRL_RST;
      timer_control_one <= `CCBT_CTRL_RST;
      reset_match_value <= `CCBT_WORD_RST;
      channel0_compare_value <= `CCBT_WORD_RST;
      count_source_divider <= `CCBT_DIV_RST;
    end else if (clk_en && wr_fire) begin
      if (aw_addr == `CCBT_CTRL0_OFS) begin
        timer_control_zero <= 8'(ccbt_merge({24'h0, timer_control_zero}, w_data, w_strb));
      end else if (aw_addr == `CCBT_CTRL1_OFS) begin
        timer_control_one <= 8'(ccbt_merge({24'h0, timer_control_one}, w_data, w_strb));
      end else if (aw_addr == `CCBT_RMATCH_OFS) begin
        reset_match_value <= CW'(ccbt_merge({16'h0, reset_match_value}, w_data, w_strb));
      end else if (aw_addr == `CCBT_DIV_OFS) begin
        count_source_divider <= 8'(ccbt_merge({24'h0, count_source_divider}, w_data, w_strb));
      end else if (aw_addr == `CCBT_CH0CMP_OFS) begin
        channel0_compare_value <= CW'(ccbt_merge({16'h0, channel0_compare_value}, w_data,
                                                 w_strb));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base counter
  logic cnt_wr;
  logic pin_rst;
  logic hit_rm;
  logic hit_c0;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wr_val;
  assign cnt_wr = wr_fire && (aw_addr == `CCBT_COUNT_OFS) && timer_run_bit;
  assign wr_val = CW'(ccbt_merge({16'h0, base_counter_value}, w_data, w_strb));
  assign pin_rst = pin_reset_enable && !pin_st; // level-held reset
  assign hit_rm = reset_match_enable && (base_counter_value == reset_match_value);
  assign hit_c0 = channel0_match_reset_enable
                  && (base_counter_value == channel0_compare_value);
  always_comb begin
    next_count = base_counter_value;
    case (count_method_select)
      ccbt_pkg::CCBT_METH_UPDN: next_count = down_dir ? base_counter_value - 1'b1
                                                      : base_counter_value + 1'b1;
      ccbt_pkg::CCBT_METH_QUAD: next_count = q_up ? base_counter_value + 1'b1
                                                  : base_counter_value - 1'b1;
      default: next_count = base_counter_value + 1'b1; // wraps at all-ones
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_counter_value <= `CCBT_WORD_RST;
      down_dir <= 1'b0;
      match_hold <= 1'b0;
    end else if (clk_en) begin
      if (!timer_run_bit || pin_rst) begin
        base_counter_value <= `CCBT_WORD_RST;
        down_dir <= 1'b0;
        match_hold <= 1'b0;
      end else if (cnt_wr) begin
        base_counter_value <= wr_val; // continues from the written value
        match_hold <= 1'b0;
      end else if (tick) begin
        // the value after the match stands for one tick, zero loads on the next
        match_hold <= hit_rm || hit_c0;
        if (match_hold) begin
          base_counter_value <= `CCBT_WORD_RST;
          down_dir <= 1'b0;
        end else begin
          base_counter_value <= next_count;
          if (count_method_select == ccbt_pkg::CCBT_METH_UPDN) begin
            if (!down_dir && base_counter_value == 16'hFFFE) down_dir <= 1'b1;
            else if (down_dir && base_counter_value == 16'h0001) down_dir <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request: overflow of bit 14 or 15, or reset-match; pin reset gives none
  logic ovf;
  logic req;
  logic pend_clr;
  assign ovf = tick && !match_hold && !cnt_wr && (overflow_bit_select
             ? (base_counter_value[15] && !next_count[15])
             : (base_counter_value[14] && !next_count[14]));
  assign req = timer_run_bit && !pin_rst
               && (ovf || (tick && !cnt_wr && hit_rm));
  assign pend_clr = wr_fire && (aw_addr == `CCBT_STATUS_OFS) && w_strb[0]
                    && w_data[`CCBT_PEND_BIT];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 1'b0;
      base_timer_irq <= 1'b0;
    end else if (clk_en) begin
      if (req) pend <= 1'b1; // set wins over clear
      else if (pend_clr) pend <= 1'b0;
      base_timer_irq <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel and counter view
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      base_counter_out <= `CCBT_WORD_RST;
    end else if (clk_en) begin
      base_counter_out <= base_counter_value;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `CCBT_CTRL0_OFS) s_axi_rdata <= {24'h0, timer_control_zero};
        else if (s_axi_araddr == `CCBT_CTRL1_OFS) s_axi_rdata <= {24'h0, timer_control_one};
        else if (s_axi_araddr == `CCBT_COUNT_OFS)
          s_axi_rdata <= {16'h0, base_counter_value};
        else if (s_axi_araddr == `CCBT_RMATCH_OFS) s_axi_rdata <= {16'h0, reset_match_value};
        else if (s_axi_araddr == `CCBT_DIV_OFS) s_axi_rdata <= {24'h0, count_source_divider};
        else if (s_axi_araddr == `CCBT_CH0CMP_OFS)
          s_axi_rdata <= {16'h0, channel0_compare_value};
        else if (s_axi_araddr == `CCBT_STATUS_OFS) s_axi_rdata <= {30'h0, timer_run_bit, pend};
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* test/ccbt_top_sva.sv */
// concurrent checks on the base timer ports, with a shadow of the control writes
// assumes full byte strobes and at most one write in flight
`timescale 1ns/1ps
`include "ccbt_regs.svh"
module ccbt_top_sva #(
  parameter int CW = 16
) (
  // clock, reset and pin
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic external_interrupt_pin_one,
  // write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // timer state
  input wire logic base_timer_irq,
  input wire logic [CW-1:0] base_counter_out
);
  logic [7:0] wa;
  logic [15:0] wd, rm;
  logic [4:0] c0, c1;
  logic [2:0] qc;
  logic q, run, pen, up, updn, rmen, ovs;
  // shadow control, applied when the write response is accepted
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wa <= 8'h00;
      wd <= 16'h0000;
      rm <= 16'h0000;
      c0 <= 5'h00;
      c1 <= 5'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[15:0];
      if (s_axi_bvalid && s_axi_bready && wa == `CCBT_CTRL0_OFS) c0 <= wd[4:0];
      if (s_axi_bvalid && s_axi_bready && wa == `CCBT_CTRL1_OFS) c1 <= wd[4:0];
      if (s_axi_bvalid && s_axi_bready && wa == `CCBT_RMATCH_OFS) rm <= wd;
    end
  end
  // quiet time since a write or a pin reset; counter loads are not plain steps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) qc <= 3'h0;
    else if (s_axi_bvalid || !external_interrupt_pin_one) qc <= 3'h0;
    else if (qc != 3'h7) qc <= qc + 3'h1;
  end
  assign q = (qc == 3'h7);
  assign run = c1[2];
  assign pen = c1[1];
  assign up = (c1[4:3] == 2'h0);
  assign updn = (c1[4:3] == 2'h1);
  assign rmen = c0[2];
  assign ovs = c0[3];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_at_match;
    q && run && up && rmen && rm != 16'h0000 && base_counter_out == rm;
  endsequence
  sequence s_left_match;
    s_at_match ##1 base_counter_out != rm;
  endsequence
  // the value after the match stands one tick, then zero loads
  property p_match_zero;
    s_left_match |-> base_counter_out == rm + 16'h0001
      ##1 (base_counter_out == rm + 16'h0001 || base_counter_out == 16'h0000);
  endproperty
  a_match_zero: assert property (p_match_zero) else $error("match did not clear");
  property p_up_step;
    q && run && up && !rmen && !c1[0] && base_counter_out != $past(base_counter_out)
      |-> base_counter_out == $past(base_counter_out) + 16'h0001;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up count step wrong");
  property p_pin_reset;
    (pen && run && !external_interrupt_pin_one) [*8] |-> base_counter_out == 16'h0000;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not held");
  property p_pin_no_irq;
    (pen && !rmen && !external_interrupt_pin_one) [*8] |-> !base_timer_irq;
  endproperty
  a_pin_no_irq: assert property (p_pin_no_irq) else $error("pin reset raised irq");
  property p_stopped;
    (!run) [*4] |-> base_counter_out == 16'h0000;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped count not zero");
  property p_irq_pulse;
    base_timer_irq |=> !base_timer_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than a pulse");
  property p_updn_turn;
    q && run && updn && base_counter_out == 16'hFFFF ##1 base_counter_out != 16'hFFFF
      |-> base_counter_out == 16'hFFFE;
  endproperty
  a_updn_turn: assert property (p_updn_turn) else $error("no turn at top");
  property p_ovf_irq;
    q && run && up && !ovs && $past(base_counter_out) == 16'h7FFF
      && base_counter_out == 16'h8000 |-> (base_timer_irq || $past(base_timer_irq))
      or (##1 base_timer_irq);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("no overflow irq");
endmodule
bind ccbt_top ccbt_top_sva #(.CW(CW)) ccbt_top_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .external_interrupt_pin_one(external_interrupt_pin_one), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .base_timer_irq(base_timer_irq),
  .base_counter_out(base_counter_out));

/* test/ccbt_encoder_model.sv */
// quadrature encoder and reset pin standing outside the base timer
// assumes the bench strobes one step per clock at most
`timescale 1ns/1ps
module ccbt_encoder_model (
  // bench commands
  input wire logic ref_clk,
  input wire logic step_fwd,
  input wire logic step_back,
  input wire logic pin_low,
  // pins towards the timer
  output logic quadrature_input_a,
  output logic quadrature_input_b,
  output logic external_interrupt_pin_one
);
  logic [1:0] phase = 2'h0;
  // gray walk, one edge per step; a leads b going forward
  always_ff @(posedge ref_clk) begin
    if (step_fwd) phase <= phase + 2'h1;
    else if (step_back) phase <= phase - 2'h1;
  end
  assign quadrature_input_a = phase[1] ^ phase[0];
  assign quadrature_input_b = phase[1];
  assign external_interrupt_pin_one = !pin_low; // pulled up when released
endmodule

/* test/capture_compare_base_timer_tb_top.sv */
// self-checking bench of the base timer over axi4-lite
// assumes the encoder model drives the pins; count ticks come from one bench strobe
`timescale 1ns/1ps
`include "ccbt_regs.svh"
module capture_compare_base_timer_tb_top;
  logic ref_clk, reset_n, tk, fwd, back, pin_low, qa, qb, pin, irq;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [15:0] cnt, v;
  logic [17:0] exp_r;
  logic [17:0] expq[$];
  logic [1:0] wq[$];
  int num_errors, samples_checked, irq_cnt, ic;
  ccbt_top ccbt_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
    .internal_clock_one(tk), .internal_clock_two(tk), .quadrature_input_a(qa),
    .quadrature_input_b(qb), .external_interrupt_pin_one(pin), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .base_timer_irq(irq), .base_counter_out(cnt));
  ccbt_encoder_model ccbt_encoder_model_inst (.ref_clk(ref_clk), .step_fwd(fwd),
    .step_back(back), .pin_low(pin_low), .quadrature_input_a(qa),
    .quadrature_input_b(qb), .external_interrupt_pin_one(pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // master holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    wq.push_back(2'h0);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) num_errors++;
    if (n == 100) give_verdict();
  endtask
  // read notes the expected word; the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, d});
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) num_errors++;
    if (n == 100) give_verdict();
  endtask
  // idle first so the checker sees quiet time, then n count ticks
  task automatic tick(input int n);
    repeat (8) @(posedge ref_clk);
    repeat (n) begin
      @(posedge ref_clk);
      tk <= 1'b1;
    end
    @(posedge ref_clk);
    tk <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic step(input logic f, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      fwd <= f;
      back <= !f;
      @(posedge ref_clk);
      fwd <= 1'b0;
      back <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor takes the oldest note for each read answer
  always @(posedge ref_clk) begin
    if (irq === 1'b1) irq_cnt++;
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check("write resp", {30'h0, bresp}, {30'h0, wq.pop_front()});
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      exp_r = expq.pop_front();
      check("read data", rdata, {16'h0000, exp_r[15:0]});
      check("read resp", {30'h0, rresp}, {30'h0, exp_r[17:16]});
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    {reset_n, tk, fwd, back, pin_low, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, num_errors, samples_checked, irq_cnt} = '0;
    seed = 32'h5F677AC6;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(`CCBT_COUNT_OFS, 16'h0000, 2'h0);
    wr(`CCBT_COUNT_OFS, 16'h1234);
    rd(`CCBT_COUNT_OFS, 16'h0000, 2'h0);
    rd(8'h40, 16'h0000, 2'h2);
    $display("test stopped done");
    wr(`CCBT_CTRL1_OFS, 16'h0004);
    tick(3);
    rd(`CCBT_COUNT_OFS, 16'h0003, 2'h0);
    seed = lfsr(seed);
    v = {2'b00, seed[13:0]};
    wr(`CCBT_COUNT_OFS, v);
    tick(3);
    rd(`CCBT_COUNT_OFS, v + 16'h0003, 2'h0);
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    wr(`CCBT_CTRL0_OFS, 16'h0001);
    wr(`CCBT_DIV_OFS, 16'h0003);
    wr(`CCBT_CTRL1_OFS, 16'h0004);
    tick(8);
    rd(`CCBT_COUNT_OFS, 16'h0002, 2'h0);
    wr(`CCBT_DIV_OFS, 16'h0000);
    $display("test load and divide done");
    wr(`CCBT_CTRL0_OFS, 16'h0000);
    ic = irq_cnt;
    wr(`CCBT_COUNT_OFS, 16'h7FFF);
    tick(1);
    check("irq bit 14", irq_cnt, ic + 1);
    wr(`CCBT_CTRL0_OFS, 16'h0008);
    wr(`CCBT_COUNT_OFS, 16'hFFFF);
    tick(1);
    check("irq bit 15", irq_cnt, ic + 2);
    rd(`CCBT_STATUS_OFS, 16'h0003, 2'h0);
    wr(`CCBT_STATUS_OFS, 16'h0001);
    rd(`CCBT_STATUS_OFS, 16'h0002, 2'h0);
    $display("test overflow done");
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    seed = lfsr(seed);
    v = 16'h0003 + {13'h0, seed[2:0]};
    wr(`CCBT_RMATCH_OFS, v);
    wr(`CCBT_CTRL0_OFS, 16'h0004);
    wr(`CCBT_CTRL1_OFS, 16'h0004);
    ic = irq_cnt;
    tick(int'(v) + 3);
    rd(`CCBT_COUNT_OFS, 16'h0001, 2'h0);
    check("irq match", irq_cnt, ic + 1);
    wr(`CCBT_CTRL0_OFS, 16'h0000);
    // channel 0 is taken as in waveform output with its function enabled
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    wr(`CCBT_CH0CMP_OFS, v);
    wr(`CCBT_CTRL1_OFS, 16'h0005);
    tick(int'(v) + 3);
    rd(`CCBT_COUNT_OFS, 16'h0001, 2'h0);
    $display("test match done");
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    wr(`CCBT_CTRL1_OFS, 16'h000C);
    wr(`CCBT_COUNT_OFS, 16'hFFFD);
    tick(4);
    rd(`CCBT_COUNT_OFS, 16'hFFFD, 2'h0);
    wr(`CCBT_COUNT_OFS, 16'h0002);
    tick(4);
    rd(`CCBT_COUNT_OFS, 16'h0002, 2'h0);
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    wr(`CCBT_CTRL0_OFS, 16'h0002);
    wr(`CCBT_CTRL1_OFS, 16'h0014);
    step(1'b1, 6);
    step(1'b0, 2);
    rd(`CCBT_COUNT_OFS, 16'h0004, 2'h0);
    $display("test up down and quadrature done");
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    wr(`CCBT_CTRL0_OFS, 16'h0000);
    wr(`CCBT_CTRL1_OFS, 16'h0006);
    tick(5);
    ic = irq_cnt;
    @(posedge ref_clk);
    pin_low <= 1'b1;
    tick(3);
    check("held count", {16'h0000, cnt}, 32'h0000_0000);
    check("irq pin", irq_cnt, ic);
    @(posedge ref_clk);
    pin_low <= 1'b0;
    tick(2);
    rd(`CCBT_COUNT_OFS, 16'h0002, 2'h0);
    wr(`CCBT_CTRL1_OFS, 16'h0000);
    rd(`CCBT_COUNT_OFS, 16'h0000, 2'h0);
    $display("test pin reset and stop done");
    give_verdict();
  end
endmodule
